// *** sadc_pkg.sv ***
// Purpose: shared constants and types of the sar converter sequencer
// Assumes: axi4-lite register bus with 32-bit data, one clock
// Notes:   every offset, field position, reset value and count lives here

package sadc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COMMAND = 8'h04;
    localparam logic [7:0] OFF_SELECT = 8'h08;
    localparam logic [7:0] OFF_TIMING = 8'h0c;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_RESULT = 8'h14;
    localparam logic [7:0] OFF_ACTIVE = 8'h18;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_FREE_RUN = 1;
    localparam int CTRL_RES_SEL = 2;
    localparam int CTRL_EV_START = 3;
    localparam int CTRL_PRESCALE_SELECT_LO = 8;
    localparam int CTRL_ACC_LO = 12;
    localparam int CMD_START = 0;
    localparam int SEL_CHAN_LO = 0;
    localparam int SEL_REF_LO = 8;
    localparam int TIM_DLY_LO = 0;
    localparam int TIM_LEN_LO = 8;
    localparam int FLG_READY = 0;
    localparam int FLG_IRQ_EN = 8;

    localparam int CHAN_W = 5;
    localparam int REF_W = 2;
    localparam int PRESCALE_SELECT_W = 3;
    localparam int ACC_W = 3;
    localparam int DLY_W = 4;
    localparam int LEN_W = 8;
    localparam int SAMPLE_W = 10;
    localparam int RESULT_W = 16;
    localparam int CYC_W = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SELECT_RST = 32'h0000_0000;
    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic FLG_IRQ_EN_RST = 1'b0;

    // ------------------------------------------------------------
    // timing counts, in converter clock cycles, and the largest accumulation selection
    // ------------------------------------------------------------
    localparam logic [CYC_W-1:0] CONV_CYCLES = 9'h00d;
    localparam logic [CYC_W-1:0] HOLD_CYCLES = 9'h002;
    localparam logic [ACC_W-1:0] ACC_MAX_SEL = 3'h6;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } sadc_state_t;

endpackage

// *** sadc_prescaler.sv ***
// Purpose: converter clock prescaler, one enable pulse per converter clock
// Assumes: run low holds the counter at zero
// Notes:   tick marks the rising edge of the converter clock

`timescale 1ns/1ps

module sadc_prescaler (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [sadc_pkg::PRESCALE_SELECT_W-1:0] prescale_select_sel,
    output logic tick
);

    logic [7:0] cnt_q;
    logic [7:0] half;
    logic [7:0] last;

    // factor is 2 << prescale_select_sel, 2 up to 256
    assign half = 8'h01 << prescale_select_sel;
    assign last = (half << 1) - 8'h01;

    // ------------------------------------------------------------
    // counter, held at zero while idle so the start delay is fixed
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
        end else if (!run) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == last) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 1'b0;
        end else begin
            tick <= run && (cnt_q == half - 8'h01);
        end
    end

    prescale_select_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        !run |=> (cnt_q == 8'h00) && !tick)
        else $error("prescaler ran while idle");

endmodule

// *** sadc_sar_model.sv ***
// Purpose: analog core stand-in for the sequencer
// Assumes: the code is settled long before a conversion ends
// Notes:   code carries the active selection, so a wrong lock shows up

`timescale 1ns/1ps

module sadc_sar_model (
    input wire logic [sadc_pkg::CHAN_W-1:0] sar_channel,
    input wire logic [sadc_pkg::REF_W-1:0] sar_reference,
    output logic [sadc_pkg::SAMPLE_W-1:0] sar_data
);
    assign sar_data = {sar_reference, sar_channel, 3'h3};
endmodule

// *** sadc_sequencer.sv ***
// Purpose: conversion sequencer of a 10-bit sar converter, axi4-lite slave
// Assumes: sar_data settles before the last converter cycle; pins are asynchronous
// Notes:   one write and one read under way at a time; no wait states beyond two
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.

`timescale 1ns/1ps

// Notes on behaviour
// - writing start begins a conversion; bit reads one while busy, single mode clears it
// - channel change during conversion takes effect only after it finishes
// - completion of a sample or full accumulation sets the ready flag; irq needs both enables
// - ready flag sets even when its interrupt enable is off
// - with event start enabled an incoming event triggers a conversion unless one is already under way
// - event input is edge sensitive, sets start bit, cleared at completion unless free running
// - free running: start bit begins first; each later one starts right after completion
// - prescaler divides the peripheral clock, runs only while enabled
// - prescaler held reset while idle; conversion starts at next converter clock edge
// - conversion lasts 13 plus delay plus length converter clocks; sample-hold 2 plus delay plus length after start
// - ready flag clears on result read or writing one to it
// - sampling lasts 2 plus delay plus length converter clocks
// - free-running period is 13 plus delay plus length converter clocks
// - channel and reference pass a buffer, copied continuously until a start
// - selections lock during conversion, update again in its last cycle
// - result is one sample or the sum of the configured sample count
// - result is 10 bits per sample, 8 with reduced resolution, right justified
// - free running: next result after a channel change still uses the old channel
module sadc_sequencer (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_trigger,
    input wire logic global_int_enable,
    input wire logic [sadc_pkg::SAMPLE_W-1:0] sar_data,
    output logic [sadc_pkg::CHAN_W-1:0] sar_channel,
    output logic [sadc_pkg::REF_W-1:0] sar_reference,
    output logic sar_sample_hold,
    output logic sar_busy,
    output logic result_ready_irq
);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == sadc_pkg::OFF_CTRL || a == sadc_pkg::OFF_COMMAND ||
               a == sadc_pkg::OFF_SELECT || a == sadc_pkg::OFF_TIMING ||
               a == sadc_pkg::OFF_FLAGS || a == sadc_pkg::OFF_RESULT ||
               a == sadc_pkg::OFF_ACTIVE;
    endfunction

    logic [31:0] ctrl_q;
    logic [31:0] sel_buf_q;
    logic [31:0] timing_q;
    logic irq_en_q;
    logic start_q;
    logic ready_q;
    logic [sadc_pkg::RESULT_W-1:0] result_q;
    logic [sadc_pkg::CHAN_W+sadc_pkg::REF_W-1:0] act_sel_q;
    sadc_pkg::sadc_state_t state_q;
    logic [sadc_pkg::CYC_W-1:0] cyc_q;
    logic [6:0] smp_q;
    logic [sadc_pkg::RESULT_W-1:0] acc_q;
    logic ev_s1_q, ev_s2_q, ev_s3_q;
    logic [sadc_pkg::SAMPLE_W-1:0] sd_s1_q, sd_s2_q;
    logic [sadc_pkg::SAMPLE_W-1:0] code_q;
    logic aw_rdy_q, ar_rdy_q;
    logic tick;

    logic wr_fire, rd_fire, wr_map;
    logic enable, free_run, ev_rise, ev_start, sw_start;
    logic [sadc_pkg::CYC_W-1:0] total, hold_pt;
    logic [6:0] n_smp;
    logic conv_end, seq_end, locked, flag_clr;
    logic [sadc_pkg::RESULT_W-1:0] sample, sum;

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !aw_rdy_q && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && !ar_rdy_q && !s_axi_rvalid;
    assign wr_map = wr_fire && mapped(s_axi_awaddr);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aw_rdy_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sadc_pkg::RESP_OKAY;
        end else begin
            aw_rdy_q <= wr_fire;
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
            if (wr_fire) begin
                s_axi_bresp <= wr_map ? sadc_pkg::RESP_OKAY : sadc_pkg::RESP_SLVERR;
            end
            // response only after both channels have been taken
            if (aw_rdy_q) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ar_rdy_q <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sadc_pkg::RESP_OKAY;
        end else begin
            ar_rdy_q <= rd_fire;
            s_axi_arready <= rd_fire;
            if (rd_fire) begin
                s_axi_rresp <= mapped(s_axi_araddr) ? sadc_pkg::RESP_OKAY
                                                    : sadc_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    sadc_pkg::OFF_CTRL: s_axi_rdata <= ctrl_q;
                    sadc_pkg::OFF_COMMAND: s_axi_rdata <= {31'h0, start_q};
                    sadc_pkg::OFF_SELECT: s_axi_rdata <= sel_buf_q;
                    sadc_pkg::OFF_TIMING: s_axi_rdata <= timing_q;
                    sadc_pkg::OFF_FLAGS: s_axi_rdata <= {23'h0, irq_en_q, 7'h0, ready_q};
                    sadc_pkg::OFF_RESULT: s_axi_rdata <= {16'h0, result_q};
                    sadc_pkg::OFF_ACTIVE: begin
                        s_axi_rdata <= {22'h0, act_sel_q[6:5], 3'h0, act_sel_q[4:0]};
                    end
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (ar_rdy_q) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= sadc_pkg::CTRL_RST;
            sel_buf_q <= sadc_pkg::SELECT_RST;
            timing_q <= sadc_pkg::TIMING_RST;
            irq_en_q <= sadc_pkg::FLG_IRQ_EN_RST;
        end else if (wr_map) begin
            case (s_axi_awaddr)
                sadc_pkg::OFF_CTRL: ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
                sadc_pkg::OFF_SELECT: begin
                    sel_buf_q <= merge(sel_buf_q, s_axi_wdata, s_axi_wstrb);
                end
                sadc_pkg::OFF_TIMING: timing_q <= merge(timing_q, s_axi_wdata, s_axi_wstrb);
                sadc_pkg::OFF_FLAGS: begin
                    if (s_axi_wstrb[1]) begin
                        irq_en_q <= s_axi_wdata[sadc_pkg::FLG_IRQ_EN];
                    end
                end
                default: ;
            endcase
        end
    end

    assign enable = ctrl_q[sadc_pkg::CTRL_ENABLE];
    assign free_run = ctrl_q[sadc_pkg::CTRL_FREE_RUN];
    assign total = sadc_pkg::CONV_CYCLES
                 + 9'(timing_q[sadc_pkg::TIM_DLY_LO +: sadc_pkg::DLY_W])
                 + 9'(timing_q[sadc_pkg::TIM_LEN_LO +: sadc_pkg::LEN_W]);
    assign hold_pt = sadc_pkg::HOLD_CYCLES
                   + 9'(timing_q[sadc_pkg::TIM_DLY_LO +: sadc_pkg::DLY_W])
                   + 9'(timing_q[sadc_pkg::TIM_LEN_LO +: sadc_pkg::LEN_W]);
    // selections above the largest accumulation count clamp to 64 samples
    assign n_smp = (ctrl_q[sadc_pkg::CTRL_ACC_LO +: sadc_pkg::ACC_W] > sadc_pkg::ACC_MAX_SEL)
                 ? 7'h40 : 7'h01 << ctrl_q[sadc_pkg::CTRL_ACC_LO +: sadc_pkg::ACC_W];

    // ------------------------------------------------------------
    // event input and start bit
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_s3_q <= 1'b0;
            sd_s1_q <= '0;
            sd_s2_q <= '0;
        end else begin
            ev_s1_q <= event_trigger;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            sd_s1_q <= sar_data;
            sd_s2_q <= sd_s1_q;
        end
    end

    assign ev_rise = ev_s2_q && !ev_s3_q;
    assign ev_start = ev_rise && ctrl_q[sadc_pkg::CTRL_EV_START] && enable;
    assign sw_start = wr_map && s_axi_awaddr == sadc_pkg::OFF_COMMAND && s_axi_wstrb[0]
                   && s_axi_wdata[sadc_pkg::CMD_START] && enable;
    assign conv_end = tick && state_q == sadc_pkg::ST_CONV && cyc_q + 9'h001 == total;
    assign seq_end = conv_end && smp_q + 7'h01 >= n_smp;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            start_q <= 1'b0;
        end else if (!enable) begin
            start_q <= 1'b0;
        end else if (sw_start || ev_start) begin
            start_q <= 1'b1;
        end else if (seq_end && !free_run) begin
            start_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer, advanced on converter clock edges
    // ------------------------------------------------------------
    sadc_prescaler u_prescale_select (
        .clock(clock),
        .rst_b(rst_b),
        .run(enable && state_q != sadc_pkg::ST_IDLE),
        .prescale_select_sel(ctrl_q[sadc_pkg::CTRL_PRESCALE_SELECT_LO +: sadc_pkg::PRESCALE_SELECT_W]),
        .tick(tick)
    );

    // code taken as the last converter cycle begins, while the selection is still
    // locked, so a channel change cannot reach this result even at slow prescales
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            code_q <= '0;
        end else if (tick && state_q == sadc_pkg::ST_CONV && cyc_q + 9'h002 == total) begin
            code_q <= sd_s2_q;
        end
    end

    assign sample = ctrl_q[sadc_pkg::CTRL_RES_SEL] ? 16'(code_q[9:2]) : 16'(code_q);
    assign sum = (smp_q == 7'h00) ? sample : acc_q + sample;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= sadc_pkg::ST_IDLE;
            cyc_q <= '0;
            smp_q <= 7'h00;
            acc_q <= '0;
        end else if (!enable) begin
            state_q <= sadc_pkg::ST_IDLE;
            cyc_q <= '0;
            smp_q <= 7'h00;
        end else begin
            case (state_q)
                sadc_pkg::ST_IDLE: begin
                    if (start_q) begin
                        state_q <= sadc_pkg::ST_WAIT;
                    end
                end
                sadc_pkg::ST_WAIT: begin
                    if (tick) begin
                        state_q <= sadc_pkg::ST_CONV;
                        cyc_q <= '0;
                        smp_q <= 7'h00;
                    end
                end
                sadc_pkg::ST_CONV: begin
                    if (conv_end) begin
                        acc_q <= sum;
                        cyc_q <= '0;
                        if (!seq_end) begin
                            smp_q <= smp_q + 7'h01;
                        end else begin
                            smp_q <= 7'h00;
                            // free running: next conversion follows with no gap
                            if (!(free_run && start_q)) begin
                                state_q <= sadc_pkg::ST_IDLE;
                            end
                        end
                    end else if (tick) begin
                        cyc_q <= cyc_q + 9'h001;
                    end
                end
                default: state_q <= sadc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result, ready flag and selection lock
    // ------------------------------------------------------------
    assign flag_clr = (wr_map && s_axi_awaddr == sadc_pkg::OFF_FLAGS && s_axi_wstrb[0]
                    && s_axi_wdata[sadc_pkg::FLG_READY])
                   || (rd_fire && s_axi_araddr == sadc_pkg::OFF_RESULT);
    // unlocked in the last converter cycle so a pending change lands before the next
    assign locked = state_q == sadc_pkg::ST_CONV && cyc_q + 9'h001 != total;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            result_q <= '0;
        end else begin
            ready_q <= seq_end || (ready_q && !flag_clr);
            if (seq_end) begin
                result_q <= sum;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            act_sel_q <= '0;
        end else if (!locked) begin
            act_sel_q <= {sel_buf_q[sadc_pkg::SEL_REF_LO +: sadc_pkg::REF_W],
                          sel_buf_q[sadc_pkg::SEL_CHAN_LO +: sadc_pkg::CHAN_W]};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sar_sample_hold <= 1'b0;
            sar_busy <= 1'b0;
            result_ready_irq <= 1'b0;
        end else begin
            sar_sample_hold <= tick && state_q == sadc_pkg::ST_CONV
                            && cyc_q + 9'h001 == hold_pt;
            sar_busy <= state_q == sadc_pkg::ST_CONV;
            result_ready_irq <= ready_q && irq_en_q && global_int_enable;
        end
    end

    assign sar_channel = act_sel_q[4:0];
    assign sar_reference = act_sel_q[6:5];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    flag_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        seq_end |=> ready_q)
        else $error("ready flag missed a completion");

    flag_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        ready_q && flag_clr && !seq_end |=> !ready_q)
        else $error("ready flag not cleared");

    start_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        sw_start && state_q != sadc_pkg::ST_CONV |=> start_q ##1 state_q != sadc_pkg::ST_IDLE)
        else $error("start write did not begin a conversion");

    single_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        seq_end && !free_run && !sw_start && !ev_start |=> !start_q ##1
            state_q == sadc_pkg::ST_IDLE)
        else $error("single conversion left start bit set");

    event_start_a: assert property (@(posedge clock) disable iff (!rst_b)
        ev_start |=> start_q)
        else $error("event did not set start bit");

    conv_len_a: assert property (@(posedge clock) disable iff (!rst_b)
        conv_end |-> cyc_q == total - 9'h001 && total >= sadc_pkg::CONV_CYCLES)
        else $error("conversion length wrong");

    free_run_a: assert property (@(posedge clock) disable iff (!rst_b)
        seq_end && free_run && start_q && enable |=> state_q == sadc_pkg::ST_CONV
            && cyc_q == '0)
        else $error("free running did not restart");

    sel_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
        locked |=> $stable(act_sel_q))
        else $error("selection changed while locked");

    no_restart_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == sadc_pkg::ST_CONV && !conv_end && enable |=> state_q == sadc_pkg::ST_CONV
            && (cyc_q == $past(cyc_q) || cyc_q == $past(cyc_q) + 9'h001))
        else $error("running conversion restarted");

endmodule

// *** sadc_sequencer_bench.sv ***
// Purpose: self-checking bench of the conversion sequencer
// Assumes: full resolution runs at divide 256; reduced resolution runs faster
// Notes:   every scenario polls the ready flag; the timeout ends a hang

`timescale 1ns/1ps

module sadc_sequencer_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic event_trigger = 1'b0;
    logic gie = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, sh, busy, irq;
    logic [1:0] bresp, rresp, rresp_got;
    logic [31:0] rdata;
    logic [9:0] sar_data;
    logic [4:0] chan;
    logic [1:0] reference_select;
    int fails = 0, n_compared = 0, cyc = 0;

    always #4 clock = ~clock;

    sadc_sequencer sadc_sequencer_inst (.clock(clock), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_trigger(event_trigger),
        .global_int_enable(gie), .sar_data(sar_data), .sar_channel(chan),
        .sar_reference(reference_select), .sar_sample_hold(sh), .sar_busy(busy),
        .result_ready_irq(irq));

    sadc_sar_model sadc_sar_model_inst (.sar_channel(chan), .sar_reference(reference_select),
        .sar_data(sar_data));

    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge clock);
        bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clock);
        d = rdata;
        rresp_got = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    task automatic wait_rdy;
        logic [31:0] v;
        v = 32'h0;
        while (v[0] !== 1'b1) rd(sadc_pkg::OFF_FLAGS, v);
    endtask

    // expected code for a single 10-bit sample of this selection
    function automatic logic [31:0] code(input logic [4:0] c, input logic [1:0] r);
        return {22'h0, r, c, 3'h3};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_single;
        rc(sadc_pkg::OFF_CTRL, 32'h0);
        rc(8'h40, 32'h0);
        chk(32'(rresp_got), 32'(sadc_pkg::RESP_SLVERR));
        wr(sadc_pkg::OFF_SELECT, 32'h0105);
        wr(sadc_pkg::OFF_CTRL, 32'h701);
        wr(sadc_pkg::OFF_COMMAND, 32'h0);
        rc(sadc_pkg::OFF_COMMAND, 32'h0);
        wr(sadc_pkg::OFF_COMMAND, 32'h1);
        rc(sadc_pkg::OFF_COMMAND, 32'h1);
        // change the channel only once the conversion has really started
        while (busy !== 1'b1) @(posedge clock);
        wr(sadc_pkg::OFF_SELECT, 32'h0209);
        rc(sadc_pkg::OFF_ACTIVE, 32'h0105);
        wait_rdy;
        chk(32'(irq), 32'h0);
        rc(sadc_pkg::OFF_RESULT, code(5'h05, 2'h1));
        rc(sadc_pkg::OFF_FLAGS, 32'h0);
        rc(sadc_pkg::OFF_COMMAND, 32'h0);
        rc(sadc_pkg::OFF_ACTIVE, 32'h0209);
        wr(sadc_pkg::OFF_CTRL, 32'h0);
        $display("test single done");
    endtask

    task automatic t_event;
        wr(sadc_pkg::OFF_CTRL, 32'hd);
        event_trigger <= 1'b1;
        repeat (4) @(posedge clock);
        event_trigger <= 1'b0;
        wait_rdy;
        rc(sadc_pkg::OFF_COMMAND, 32'h0);
        wr(sadc_pkg::OFF_FLAGS, 32'h1);
        rc(sadc_pkg::OFF_FLAGS, 32'h0);
        rc(sadc_pkg::OFF_RESULT, code(5'h09, 2'h2) >> 2);
        wr(sadc_pkg::OFF_CTRL, 32'h0);
        $display("test event done");
    endtask

    task automatic t_free;
        logic [31:0] v;
        wr(sadc_pkg::OFF_CTRL, 32'h7);
        wr(sadc_pkg::OFF_COMMAND, 32'h1);
        wait_rdy;
        rd(sadc_pkg::OFF_RESULT, v);
        wait_rdy;
        rc(sadc_pkg::OFF_COMMAND, 32'h1);
        wr(sadc_pkg::OFF_CTRL, 32'h0);
        $display("test free running done");
    endtask

    // four 8-bit samples back to back at divide 4, delay 1, length 2
    task automatic t_accum;
        int n, m;
        wr(sadc_pkg::OFF_TIMING, 32'h0201);
        wr(sadc_pkg::OFF_FLAGS, 32'h101);
        wr(sadc_pkg::OFF_CTRL, 32'h2105);
        wr(sadc_pkg::OFF_COMMAND, 32'h1);
        n = 0;
        m = 0;
        while (busy !== 1'b1) @(posedge clock);
        // busy follows the start tick by two clocks, sample-hold its tick by one
        while (sh !== 1'b1) begin
            @(posedge clock);
            n++;
        end
        chk(n, (2 + 1 + 2) * 4 - 1);
        do begin
            @(posedge clock);
            m++;
        end while (sh !== 1'b1);
        chk(m, (13 + 1 + 2) * 4);
        rc(sadc_pkg::OFF_FLAGS, 32'h100);
        wait_rdy;
        chk(32'(irq), 32'h1);
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'(irq), 32'h0);
        gie <= 1'b1;
        rc(sadc_pkg::OFF_RESULT, 4 * (code(5'h09, 2'h2) >> 2));
        rc(sadc_pkg::OFF_COMMAND, 32'h0);
        wr(sadc_pkg::OFF_CTRL, 32'h0);
        $display("test accumulate done");
    endtask

    task automatic summarize;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize;
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_single;
        t_event;
        t_free;
        t_accum;
        summarize;
    end
endmodule
